// *** rtl/tcm_timer_channels.sv ***
`timescale 1ns/1ps
module tcm_timer_channels #(
  parameter int NCH = tcm_pkg::NUM_CH
) (
  input  wire logic           CLK_I,    // Bus clock, 100 MHz.
  input  wire logic           RSTN_I,   // Asynchronous reset, active low.
  input  wire logic [7:0]     ADDR_I,   // Register address.
  input  wire logic [7:0]     WDATA_I,  // Write data.
  input  wire logic           WR_I,     // Write strobe.
  input  wire logic           RD_I,     // Read strobe.
  output logic      [7:0]     RDATA_O,  // Read data, cycle after strobe.
  input  wire logic           EXT_CLK_I,// External count clock pin.
  input  wire logic [NCH-1:0] CH_PIN_I, // Channel pin levels.
  output logic      [NCH-1:0] CH_PIN_O, // Channel output levels.
  output logic      [NCH-1:0] CH_OE_O   // Channel drives its pin.
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic ch_hit(input logic [7:0] a, input int ch,
                                  input logic [7:0] sub);
    return a == 8'(tcm_pkg::OFS_CH0_CTRL + tcm_pkg::CH_STRIDE * ch + sub);
  endfunction : ch_hit

  function automatic logic [1:0] els_of(input tcm_pkg::tcm_ctrl_type c);
    return {c.edge_level_hi, c.edge_level_lo};
  endfunction : els_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                  ovf;
  logic                  next_ovf;
  logic                  ovie;
  logic                  next_ovie;
  logic                  halt;
  logic                  next_halt;
  logic [2:0]            ps;
  logic [2:0]            next_ps;
  logic [6:0]            pre;
  logic [6:0]            next_pre;
  logic [15:0]           cnt;
  logic [15:0]           next_cnt;
  logic [15:0]           modv;
  logic [15:0]           next_modv;
  logic                  mod_inh;
  logic                  next_mod_inh;
  logic                  ovf_arm;
  logic                  next_ovf_arm;
  logic [7:0]            cnt_lo_hold;
  logic [7:0]            next_cnt_lo_hold;
  logic                  cnt_held;
  logic                  next_cnt_held;
  logic [2:0]            ext_s;
  logic [2:0]            next_ext_s;
  logic                  ext_lvl;
  logic                  next_ext_lvl;

  tcm_pkg::tcm_ctrl_type ctrl      [NCH];
  tcm_pkg::tcm_ctrl_type next_ctrl [NCH];
  logic [NCH-1:0]        pin_a;
  logic [NCH-1:0]        next_pin_a;
  logic [NCH-1:0]        pin_b;
  logic [NCH-1:0]        next_pin_b;
  logic [NCH-1:0]        pin_c;
  logic [NCH-1:0]        next_pin_c;
  logic [NCH-1:0]        pin_lvl;
  logic [NCH-1:0]        next_pin_lvl;
  logic [NCH-1:0]        out_lvl;
  logic [NCH-1:0]        next_out_lvl;
  logic [NCH-1:0]        oe;
  logic [NCH-1:0]        next_oe;
  logic [NCH-1:0]        flag_arm;
  logic [NCH-1:0]        next_flag_arm;
  logic [NCH-1:0]        cap_inh;
  logic [NCH-1:0]        next_cap_inh;
  logic [NCH-1:0]        cmp_inh;
  logic [NCH-1:0]        next_cmp_inh;
  logic [NCH-1:0]        buf_sel;
  logic [NCH-1:0]        next_buf_sel;
  logic [NCH-1:0]        max_eff;
  logic [NCH-1:0]        next_max_eff;

  logic [15:0]           chval      [NCH];
  logic [15:0]           next_chval [NCH];
  logic [7:0]            rdata;
  logic [7:0]            next_rdata;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic                  tick;
  logic                  ovf_evt;
  logic                  ext_rise;
  logic [6:0]            pre_mask;
  logic [NCH-1:0]        disabled;
  logic [NCH-1:0]        cap_mode;
  logic [NCH-1:0]        cmp_mode;
  logic [NCH-1:0]        cap_evt;
  logic [NCH-1:0]        cmp_hit;
  logic [NCH-1:0]        wr_ctrl;
  logic [NCH-1:0]        wr_hi;
  logic [NCH-1:0]        wr_lo;
  logic [NCH-1:0]        rd_ctrl;
  logic [NCH-1:0]        rd_hi;
  logic [NCH-1:0]        rd_lo;
  logic [15:0]           cmp_val [NCH];

  assign ext_rise = (ext_s[1] == ext_s[2]) && ext_s[2] && !ext_lvl;
  assign pre_mask = 7'((8'h01 << ps) - 8'h01);
  assign tick     = !halt && ((ps == tcm_pkg::PS_EXT) ? ext_rise
                                                      : ((pre & pre_mask) == pre_mask));
  assign ovf_evt  = tick && (cnt == modv);

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      wr_ctrl[i]  = WR_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_CTRL);
      wr_hi[i]    = WR_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_HI);
      wr_lo[i]    = WR_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_LO);
      rd_ctrl[i]  = RD_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_CTRL);
      rd_hi[i]    = RD_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_HI);
      rd_lo[i]    = RD_I && ch_hit(ADDR_I, i, tcm_pkg::SUB_LO);
      disabled[i] = (i % 2 == 1) && ctrl[(i / 2) * 2].buffered_mode_select;
      cap_mode[i] = !disabled[i] && (els_of(ctrl[i]) != 2'h0) &&
                    !ctrl[i].buffered_mode_select && !ctrl[i].mode_select_a;
      cmp_mode[i] = !disabled[i] && (els_of(ctrl[i]) != 2'h0) &&
                    (ctrl[i].buffered_mode_select || ctrl[i].mode_select_a);
      cmp_val[i]  = (ctrl[i].buffered_mode_select && buf_sel[i]) ?
                    chval[(i / 2) * 2 + 1] : chval[i];
      cmp_hit[i]  = tick && cmp_mode[i] && !cmp_inh[i] && (cnt == cmp_val[i]);
      cap_evt[i]  = cap_mode[i] && !halt && !cap_inh[i] &&
                    (pin_b[i] == pin_c[i]) && (pin_c[i] != pin_lvl[i]) &&
                    (pin_c[i] ? ctrl[i].edge_level_lo : ctrl[i].edge_level_hi);
    end
  end

  // ----------------------------------------------------------------
  // Counter and status
  // ----------------------------------------------------------------
  always_comb begin
    next_ovf         = ovf;
    next_ovie        = ovie;
    next_halt        = halt;
    next_ps          = ps;
    next_pre         = pre;
    next_cnt         = cnt;
    next_modv        = modv;
    next_mod_inh     = mod_inh;
    next_ovf_arm     = ovf_arm;
    next_cnt_lo_hold = cnt_lo_hold;
    next_cnt_held    = cnt_held;
    next_ext_s       = {ext_s[1:0], EXT_CLK_I};
    next_ext_lvl     = (ext_s[1] == ext_s[2]) ? ext_s[2] : ext_lvl;
    if (!halt) begin
      next_pre = pre + 7'h01;
    end
    if (tick) begin
      next_cnt = (cnt == modv) ? tcm_pkg::CNT_RST : cnt + 16'h0001;
    end
    if (RD_I && ADDR_I == tcm_pkg::OFS_STATUS && ovf) begin
      next_ovf_arm = 1'b1;
    end
    if (RD_I && ADDR_I == tcm_pkg::OFS_CNT_HI) begin
      next_cnt_lo_hold = cnt[7:0];
      next_cnt_held    = 1'b1;
    end
    if (RD_I && ADDR_I == tcm_pkg::OFS_CNT_LO) begin
      next_cnt_held = 1'b0;
    end
    if (WR_I && ADDR_I == tcm_pkg::OFS_STATUS) begin
      next_ovie    = WDATA_I[tcm_pkg::ST_OVIE];
      next_halt    = WDATA_I[tcm_pkg::ST_HALT];
      next_ps      = WDATA_I[2:0];
      next_ovf_arm = 1'b0;
      if (!WDATA_I[tcm_pkg::ST_OVF] && ovf_arm) begin
        next_ovf = 1'b0;
      end
      if (WDATA_I[tcm_pkg::ST_CLR]) begin
        next_pre = tcm_pkg::PRE_RST;
        next_cnt = tcm_pkg::CNT_RST;
      end
    end
    if (WR_I && ADDR_I == tcm_pkg::OFS_MOD_HI) begin
      next_modv[15:8] = WDATA_I;
      next_mod_inh    = 1'b1;
    end
    if (WR_I && ADDR_I == tcm_pkg::OFS_MOD_LO) begin
      next_modv[7:0] = WDATA_I;
      next_mod_inh   = 1'b0;
    end
    if (ovf_evt && !mod_inh) begin
      next_ovf = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovf         <= 1'b0;
      ovie        <= 1'b0;
      halt        <= tcm_pkg::HALT_RST;
      ps          <= tcm_pkg::PS_RST;
      pre         <= tcm_pkg::PRE_RST;
      cnt         <= tcm_pkg::CNT_RST;
      modv        <= tcm_pkg::MOD_RST;
      mod_inh     <= 1'b0;
      ovf_arm     <= 1'b0;
      cnt_lo_hold <= 8'h00;
      cnt_held    <= 1'b0;
      ext_s       <= tcm_pkg::SYNC_RST;
      ext_lvl     <= 1'b0;
    end else begin
      ovf         <= next_ovf;
      ovie        <= next_ovie;
      halt        <= next_halt;
      ps          <= next_ps;
      pre         <= next_pre;
      cnt         <= next_cnt;
      modv        <= next_modv;
      mod_inh     <= next_mod_inh;
      ovf_arm     <= next_ovf_arm;
      cnt_lo_hold <= next_cnt_lo_hold;
      cnt_held    <= next_cnt_held;
      ext_s       <= next_ext_s;
      ext_lvl     <= next_ext_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  always_comb begin
    next_pin_a    = CH_PIN_I;
    next_pin_b    = pin_a;
    next_pin_c    = pin_b;
    next_pin_lvl  = pin_lvl;
    next_out_lvl  = out_lvl;
    next_oe       = oe;
    next_flag_arm = flag_arm;
    next_cap_inh  = cap_inh;
    next_cmp_inh  = cmp_inh;
    next_buf_sel  = buf_sel;
    next_max_eff  = max_eff;
    for (int i = 0; i < NCH; i++) begin
      next_ctrl[i] = ctrl[i];
      if (pin_b[i] == pin_c[i]) begin
        next_pin_lvl[i] = pin_c[i];
      end
      next_oe[i] = (els_of(ctrl[i]) != 2'h0) && !disabled[i];
      if (els_of(ctrl[i]) == 2'h0) begin
        next_out_lvl[i] = !ctrl[i].mode_select_a;
      end else if (cmp_mode[i]) begin
        if (ovf_evt && ctrl[i].toggle_on_overflow) begin
          next_out_lvl[i] = max_eff[i] ? 1'b1 : !out_lvl[i];
        end else if (cmp_hit[i] && !max_eff[i]) begin
          case (els_of(ctrl[i]))
            2'h1:    next_out_lvl[i] = !out_lvl[i];
            2'h2:    next_out_lvl[i] = 1'b0;
            2'h3:    next_out_lvl[i] = 1'b1;
            default: next_out_lvl[i] = out_lvl[i];
          endcase
        end
      end
      if (ovf_evt) begin
        next_max_eff[i] = ctrl[i].toggle_on_overflow && ctrl[i].full_duty_force;
        next_buf_sel[i] = ctrl[i].buffered_mode_select && !buf_sel[i];
      end
      if (!ctrl[i].buffered_mode_select) begin
        next_buf_sel[i] = 1'b0;
      end
      if (rd_hi[i] && cap_mode[i]) begin
        next_cap_inh[i] = 1'b1;
      end
      if (rd_lo[i]) begin
        next_cap_inh[i] = 1'b0;
      end
      if (wr_hi[i] && (ctrl[i].buffered_mode_select || ctrl[i].mode_select_a)) begin
        next_cmp_inh[i] = 1'b1;
      end
      if (wr_lo[i]) begin
        next_cmp_inh[i] = 1'b0;
      end
      if (rd_ctrl[i] && ctrl[i].flag) begin
        next_flag_arm[i] = 1'b1;
      end
      if (wr_ctrl[i] && !disabled[i]) begin
        next_flag_arm[i]                    = 1'b0;
        next_ctrl[i].irq_en                 = WDATA_I[6];
        next_ctrl[i].buffered_mode_select   = (i % 2 == 0) && WDATA_I[5];
        next_ctrl[i].mode_select_a          = WDATA_I[4];
        next_ctrl[i].edge_level_hi          = WDATA_I[3];
        next_ctrl[i].edge_level_lo          = WDATA_I[2];
        next_ctrl[i].toggle_on_overflow     = WDATA_I[1];
        next_ctrl[i].full_duty_force        = WDATA_I[0];
        if (!WDATA_I[7] && flag_arm[i]) begin
          next_ctrl[i].flag = 1'b0;
        end
      end
      if (cap_evt[i] || cmp_hit[i]) begin
        next_ctrl[i].flag = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i] <= tcm_pkg::tcm_ctrl_type'(tcm_pkg::CTRL_RST);
      end
      pin_a    <= '0;
      pin_b    <= '0;
      pin_c    <= '0;
      pin_lvl  <= '0;
      out_lvl  <= '1;
      oe       <= '0;
      flag_arm <= '0;
      cap_inh  <= '0;
      cmp_inh  <= '0;
      buf_sel  <= '0;
      max_eff  <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i] <= next_ctrl[i];
      end
      pin_a    <= next_pin_a;
      pin_b    <= next_pin_b;
      pin_c    <= next_pin_c;
      pin_lvl  <= next_pin_lvl;
      out_lvl  <= next_out_lvl;
      oe       <= next_oe;
      flag_arm <= next_flag_arm;
      cap_inh  <= next_cap_inh;
      cmp_inh  <= next_cmp_inh;
      buf_sel  <= next_buf_sel;
      max_eff  <= next_max_eff;
    end
  end

  // ----------------------------------------------------------------
  // Channel values
  // ----------------------------------------------------------------
  // Values carry no reset; software loads them before use.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      next_chval[i] = chval[i];
      if (cap_evt[i]) begin
        next_chval[i] = cnt;
      end
      if (wr_hi[i]) begin
        next_chval[i][15:8] = WDATA_I;
      end
      if (wr_lo[i]) begin
        next_chval[i][7:0] = WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      chval[i] <= next_chval[i];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        tcm_pkg::OFS_STATUS: next_rdata = {ovf, ovie, halt, 5'(ps)};
        tcm_pkg::OFS_CNT_HI: next_rdata = cnt[15:8];
        tcm_pkg::OFS_CNT_LO: next_rdata = cnt_held ? cnt_lo_hold : cnt[7:0];
        tcm_pkg::OFS_MOD_HI: next_rdata = modv[15:8];
        tcm_pkg::OFS_MOD_LO: next_rdata = modv[7:0];
        default:             next_rdata = 8'h00;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (rd_ctrl[i]) begin
          next_rdata = ctrl[i];
        end
        if (rd_hi[i]) begin
          next_rdata = chval[i][15:8];
        end
        if (rd_lo[i]) begin
          next_rdata = chval[i][7:0];
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign RDATA_O  = rdata;
  assign CH_PIN_O = out_lvl;
  assign CH_OE_O  = oe;

endmodule : tcm_timer_channels

// *** rtl/tcm_pkg.sv ***
// Functional notes
// - Buffered select bit exists on channels 0,2,4.
// - Buffered even channel disables its odd partner.
// - Reset clears every buffered select bit.
// - Nonzero edge field: select A picks function.
// - Zero edge field: select A presets level.
// - Reset clears every select A bit.
// - Zero edge field releases pin to port.
// - Capture edges: rising, falling or both.
// - Compare action: toggle, clear or set.
// - Reset clears both edge select bits.
// - Overflow toggles compare output when enabled.
// - Reset clears every toggle-on-overflow bit.
// - Overflow action beats coinciding compare action.
// - Full duty forces 100%, next period.
// - Value registers hold capture or compare value.
// - High byte read blocks capture until low.
// - High byte write blocks compare until low.
// - Flag set on capture or match only.
// - Counter clear bit self-clears, reads zero.
// - Counter wraps to zero at modulo.
package tcm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_CNT_HI   = 8'h21;
  localparam logic [7:0] OFS_CNT_LO   = 8'h22;
  localparam logic [7:0] OFS_MOD_HI   = 8'h23;
  localparam logic [7:0] OFS_MOD_LO   = 8'h24;
  localparam logic [7:0] OFS_CH0_CTRL = 8'h26;
  localparam logic [7:0] OFS_CH0_LO   = 8'h28;
  localparam logic [7:0] OFS_CH1_HI   = 8'h2a;
  localparam logic [7:0] CH_STRIDE    = 8'h03;
  localparam logic [7:0] SUB_CTRL     = 8'h00;
  localparam logic [7:0] SUB_HI       = 8'h01;
  localparam logic [7:0] SUB_LO       = 8'h02;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         ST_OVF      = 7;
  localparam int         ST_OVIE     = 6;
  localparam int         ST_HALT     = 5;
  localparam int         ST_CLR      = 4;
  localparam int         NUM_CH      = 6;
  localparam logic [2:0] PS_EXT      = 3'h7;
  localparam logic [2:0] PS_RST      = 3'h0;
  localparam logic       HALT_RST    = 1'b1;
  localparam logic [15:0] MOD_RST    = 16'hffff;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [6:0] PRE_RST     = 7'h00;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [2:0] SYNC_RST    = 3'h0;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buffered_mode_select;
    logic mode_select_a;
    logic edge_level_hi;
    logic edge_level_lo;
    logic toggle_on_overflow;
    logic full_duty_force;
  } tcm_ctrl_type;

endpackage : tcm_pkg

// *** verif/tcm_timer_channels_checker.sv ***
`timescale 1ns/1ps
module tcm_timer_channels_checker #(
  parameter int NCH = 6
) (
  input wire logic           CLK_I,     // Bus clock.
  input wire logic           RSTN_I,    // Reset, active low.
  input wire logic [7:0]     ADDR_I,    // Address.
  input wire logic [7:0]     WDATA_I,   // Write data.
  input wire logic           WR_I,      // Write strobe.
  input wire logic           RD_I,      // Read strobe.
  input wire logic [7:0]     RDATA_O,   // Read data.
  input wire logic           EXT_CLK_I, // External count clock.
  input wire logic [NCH-1:0] CH_PIN_I,  // Pin levels.
  input wire logic [NCH-1:0] CH_PIN_O,  // Output levels.
  input wire logic [NCH-1:0] CH_OE_O    // Output enables.
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_rd_status;
    RD_I && ADDR_I == 8'h20;
  endsequence
  sequence s_rd_odd_ctrl;
    RD_I && (ADDR_I == 8'h29 || ADDR_I == 8'h2f || ADDR_I == 8'h35);
  endsequence
  sequence s_ch0_off;
    WR_I && ADDR_I == 8'h26 && WDATA_I[3:2] == 2'b00;
  endsequence
  sequence s_ch0_on;
    WR_I && ADDR_I == 8'h26 && WDATA_I[3:2] != 2'b00;
  endsequence
  sequence s_ch0_buf;
    WR_I && ADDR_I == 8'h26 && WDATA_I[5];
  endsequence
  sequence s_ch2_low;
    WR_I && ADDR_I == 8'h2c && WDATA_I[4:2] == 3'b100;
  endsequence
  sequence s_ch2_high;
    WR_I && ADDR_I == 8'h2c && WDATA_I[4:2] == 3'b000;
  endsequence

  odd_buffered_zero_a: assert property (s_rd_odd_ctrl |=> RDATA_O[5] == 1'b0)
    else $error("odd channel shows a buffered bit");
  status_clear_zero_a: assert property (s_rd_status |=> RDATA_O[4:3] == 2'b00)
    else $error("counter clear bit reads nonzero");
  preset_release_a: assert property (s_ch0_off |=> ##1 !CH_OE_O[0])
    else $error("channel drives pin with zero edge field");
  compare_drive_a: assert property (s_ch0_on |=> ##1 CH_OE_O[0])
    else $error("enabled channel does not drive pin");
  odd_release_a: assert property (s_ch0_buf |=> ##1 !CH_OE_O[1])
    else $error("partner channel still drives pin");
  preset_low_a: assert property (s_ch2_low |=> ##1 !CH_PIN_O[2])
    else $error("preset low level wrong");
  preset_high_a: assert property (s_ch2_high |=> ##1 CH_PIN_O[2])
    else $error("preset high level wrong");
  oe_steady_a: assert property (!WR_I |=> ##1 $stable(CH_OE_O))
    else $error("pin enable changed without a write");
endmodule : tcm_timer_channels_checker

bind tcm_timer_channels tcm_timer_channels_checker #(.NCH(NCH)) u_checker (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .EXT_CLK_I(EXT_CLK_I), .CH_PIN_I(CH_PIN_I),
  .CH_PIN_O(CH_PIN_O), .CH_OE_O(CH_OE_O));

// *** verif/tcm_pin_model.sv ***
`timescale 1ns/1ps
module tcm_pin_model #(
  parameter int NCH = 6
) (
  input  wire logic           clk_i,   // Bus clock.
  input  wire logic [NCH-1:0] oe_i,    // Channel enables.
  input  wire logic [NCH-1:0] lvl_i,   // Channel levels.
  input  wire logic [NCH-1:0] ext_en_i,// External driver active.
  input  wire logic [NCH-1:0] ext_i,   // External level.
  output logic      [NCH-1:0] line_o   // Resolved pin level.
);
  logic [NCH-1:0] ext_q;

  // The external level only moves on a clock edge and is held between.
  always @(posedge clk_i) begin
    ext_q <= ext_i;
  end

  // A released pin with no external driver active shows the inverse of the channel level, so a stale value is never seen.
  assign line_o = (ext_en_i & ext_q) | (~ext_en_i & oe_i & lvl_i) | (~ext_en_i & ~oe_i & ~lvl_i);
endmodule : tcm_pin_model

// *** verif/tcm_timer_channels_tb.sv ***
`timescale 1ns/1ps
module tcm_timer_channels_tb;
  logic        CLK_I;
  logic        RSTN_I;
  logic        WR_I;
  logic        RD_I;
  logic        EXT_CLK_I;
  logic [7:0]  ADDR_I;
  logic [7:0]  WDATA_I;
  logic [7:0]  RDATA_O;
  logic [5:0]  CH_PIN_I;
  logic [5:0]  CH_PIN_O;
  logic [5:0]  CH_OE_O;
  logic [5:0]  ext_lvl;
  logic [5:0]  ext_en;
  logic [7:0]  exp_q[$];
  logic [7:0]  e;
  logic        rd_q;
  logic [15:0] rv;
  int          n_fail;
  int          samples_checked;
  int          seed;

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  tcm_timer_channels u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .EXT_CLK_I(EXT_CLK_I), .CH_PIN_I(CH_PIN_I),
    .CH_PIN_O(CH_PIN_O), .CH_OE_O(CH_OE_O));
  tcm_pin_model u_pins (.clk_i(CLK_I), .oe_i(CH_OE_O), .lvl_i(CH_PIN_O), .ext_en_i(ext_en),
    .ext_i(ext_lvl), .line_o(CH_PIN_I));

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wt(input int n);
    repeat (n) @(posedge CLK_I);
  endtask : wt

  task automatic ext_pulse(input int n);
    repeat (n) begin
      EXT_CLK_I <= 1'b1;
      wt(4);
      EXT_CLK_I <= 1'b0;
      wt(4);
    end
  endtask : ext_pulse

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CLK_I);
    WR_I    <= 1'b0;
    @(posedge CLK_I);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLK_I);
    RD_I   <= 1'b0;
    @(posedge CLK_I);
  endtask : rd

  task automatic end_of_test;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Read data stands only in the cycle after the strobe.
  always @(posedge CLK_I) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      cmp(RDATA_O, e);
    end
    rd_q <= RD_I;
  end

  initial begin
    wt(20000);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h3863ea2d;
    n_fail = 0;
    samples_checked = 0;
    RSTN_I = 1'b0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 8'h00;
    WDATA_I = 8'h00;
    EXT_CLK_I = 1'b0;
    ext_lvl = 6'h00;
    ext_en = 6'h10;
    wt(6);
    RSTN_I <= 1'b1;
    wt(1);
    cmp({2'b00, CH_OE_O}, 8'h00);
    cmp({2'b00, CH_PIN_O}, 8'h3f);
    for (int n = 0; n < 6; n++) rd(8'h26 + 8'(3 * n), 8'h00);
    rd(8'h20, 8'h20);
    rd(8'h10, 8'h00);
    rv = 16'($random(seed));
    wr(8'h2a, rv[15:8]);
    wr(8'h2b, rv[7:0]);
    rd(8'h2a, rv[15:8]);
    rd(8'h2b, rv[7:0]);
    wr(8'h20, 8'h30);
    wr(8'h26, 8'h34);
    wr(8'h29, 8'h14);
    rd(8'h26, 8'h34);
    rd(8'h29, 8'h00);
    cmp({7'h00, CH_OE_O[1]}, 8'h00);
    wr(8'h26, 8'h00);
    wr(8'h29, 8'h20);
    rd(8'h29, 8'h00);
    wr(8'h2c, 8'h10);
    wt(1);
    cmp({6'h00, CH_OE_O[2], CH_PIN_O[2]}, 8'h00);
    wr(8'h2c, 8'h00);
    // Toggle, clear and set, each from a preset that makes the action visible.
    for (int m = 1; m < 4; m++) begin
      wr(8'h20, 8'h30);
      wr(8'h2f, (m == 2) ? 8'h00 : 8'h10);
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h05);
      wr(8'h23, 8'h00);
      wr(8'h24, 8'h10);
      wr(8'h2f, 8'h10 | 8'(m << 2));
      wr(8'h20, 8'h00);
      wt(12);
      cmp({7'h00, CH_PIN_O[3]}, {7'h00, m != 2});
      wt(18);
      cmp({7'h00, CH_PIN_O[3]}, {7'h00, m == 3});
      rd(8'h2f, 8'h90 | 8'(m << 2));
      wr(8'h2f, 8'h00);
    end
    wr(8'h20, 8'h30);
    wr(8'h2f, 8'h10);
    wr(8'h2f, 8'h1c);
    wr(8'h30, 8'h00);
    wr(8'h20, 8'h00);
    wt(30);
    cmp({7'h00, CH_PIN_O[3]}, 8'h00);
    rd(8'h2f, 8'h1c);
    wr(8'h31, 8'h05);
    wt(30);
    cmp({7'h00, CH_PIN_O[3]}, 8'h01);
    rd(8'h20, 8'h80);
    // Toggle on overflow with clear on compare, then forced full duty.
    wr(8'h20, 8'h30);
    wr(8'h2f, 8'h10);
    wr(8'h2f, 8'h1a);
    wr(8'h20, 8'h00);
    wt(19);
    cmp({7'h00, CH_PIN_O[3]}, 8'h01);
    wt(6);
    cmp({7'h00, CH_PIN_O[3]}, 8'h00);
    wr(8'h2f, 8'h1b);
    wt(14);
    cmp({7'h00, CH_PIN_O[3]}, 8'h01);
    wt(8);
    cmp({7'h00, CH_PIN_O[3]}, 8'h01);
    // Rising, falling and either edge on a pin held steady beforehand.
    for (int c = 1; c < 4; c++) begin
      wr(8'h32, 8'(c << 2));
      wt(4);
      ext_lvl[4] <= 1'b1;
      wt(8);
      rd(8'h32, 8'(c << 2) | (c[0] ? 8'h80 : 8'h00));
      wr(8'h32, 8'(c << 2));
      ext_lvl[4] <= 1'b0;
      wt(8);
      rd(8'h32, 8'(c << 2) | (c[1] ? 8'h80 : 8'h00));
      wr(8'h32, 8'h00);
    end
    // Counter on the external clock pin, then the capture byte interlock.
    wr(8'h20, 8'h37);
    wr(8'h20, 8'h07);
    ext_pulse(3);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h03);
    wr(8'h32, 8'h0c);
    wt(4);
    ext_lvl[4] <= 1'b1;
    wt(8);
    rd(8'h33, 8'h00);
    ext_pulse(2);
    ext_lvl[4] <= 1'b0;
    wt(8);
    rd(8'h34, 8'h03);
    ext_lvl[4] <= 1'b1;
    wt(8);
    rd(8'h34, 8'h05);
    // Reset in mid-run returns live channels to their idle state.
    RSTN_I <= 1'b0;
    wt(2);
    RSTN_I <= 1'b1;
    wt(1);
    cmp({2'b00, CH_OE_O}, 8'h00);
    rd(8'h2f, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h20, 8'h20);
    wt(2);
    end_of_test();
  end
endmodule : tcm_timer_channels_tb
